// *** src/psc_pkg.sv ***
package psc_pkg;

  // apb register byte offsets
  localparam logic [7:0] PSC_CTRL_OFS = 8'h00;
  localparam logic [7:0] PSC_STRAP_OFS = 8'h04;
  localparam logic [7:0] PSC_STAT_OFS = 8'h08;
  localparam logic [7:0] PSC_IRQ_OFS = 8'h0c;
  localparam logic [7:0] PSC_MASK_OFS = 8'h10;
  localparam logic [7:0] PSC_AVSTAT_OFS = 8'h14;
  localparam logic [7:0] PSC_ADDR_OFS = 8'h18;

  // ctrl register field positions
  localparam int PSC_CTRL_OUTDIS = 0;
  localparam int PSC_CTRL_AVNEW = 1;
  localparam logic [31:0] PSC_CTRL_RST = 32'h00000000;

  // irq status bit positions
  localparam int PSC_IRQ_LOCKUP = 0;
  localparam int PSC_IRQ_LOCKDN = 1;
  localparam int PSC_IRQ_ERR = 2;
  localparam int PSC_IRQ_AVNEW = 3;
  localparam int PSC_IRQ_W = 4;

  // three-level strap code
  typedef enum logic [1:0] {
    PSC_LVL_LOW = 2'h0,
    PSC_LVL_HIGH = 2'h1,
    PSC_LVL_OPEN = 2'h2
  } psc_lvl_t;

  // address base bits
  localparam logic [7:0] PSC_ADDR_DES_BIT = 8'h10;
  localparam logic [7:0] PSC_ADDR_OPEN_BIT = 8'h02;

  typedef struct packed {
    psc_lvl_t addr0;
    psc_lvl_t addr1;
    psc_lvl_t cable;
    logic spread;
    logic rateSlow;
  } psc_straps_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } psc_apb_req_t;

  typedef enum logic [2:0] {
    PSC_ST_DOWN = 3'b001,
    PSC_ST_LATCH = 3'b010,
    PSC_ST_RUN = 3'b100
  } psc_state_t;

endpackage

// *** src/psc_tri_level.sv ***
`timescale 1ns/1ps
module psc_tri_level
  import psc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic pinHigh,
  input wire logic pinLow,
  output psc_lvl_t level
);
  // registered only on load so pin wander never glitches the code
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      level <= PSC_LVL_LOW;
    end else if (load) begin
      if (pinHigh) begin
        level <= PSC_LVL_HIGH;
      end else if (pinLow) begin
        level <= PSC_LVL_LOW;
      end else begin
        level <= PSC_LVL_OPEN;
      end
    end
  end
endmodule

// *** src/psc_edge_flag.sv ***
`timescale 1ns/1ps
module psc_edge_flag
  import psc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic setEvt,
  input wire logic clrEvt,
  output logic flag
);
  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flag <= 1'b0;
    end else if (setEvt) begin
      flag <= 1'b1;
    end else if (clrEvt) begin
      flag <= 1'b0;
    end
  end
endmodule

// *** src/psc_pin_strap_ctrl.sv ***
// Summary of operation
// - output-disable bit set floats video data and clock lanes.
// - aux enable high drives mclk, aux control 0/3, interrupt; low floats them.
// - interrupt output asserts when new A/V status content is written.
// - reading A/V status clears the interrupt output.
// - protocol select high picks two-wire bus, low picks UART host side.
// - both address straps sampled only at power-up or leaving power-down.
// - lock high while powered down, else only when PLLs locked and word boundary aligned.
// - detected or corrected link errors pull open-drain error output low.
// - while power-down is low, error and lock outputs stay high.
// - direction high: mode select picks base/bypass; low: sets power-up state.
// - spread enable latched at wake; high applies 2% spreading.
// - rate select latched at wake; high slow clock range, low fast.
// - bus-width select sets which video data lanes carry data.
// - cable-type strap is three-level, coax or twisted pair.
// - default address from latched straps, deserializer address bit 4 set.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module psc_pin_strap_ctrl
  import psc_pkg::*;
#(
  parameter int LANES = 4
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic pclk_en_unused,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_down_n,
  input wire logic aux_output_enable_in,
  input wire logic protocol_select_in,
  input wire logic link_mode_select_in,
  input wire logic control_direction_select,
  input wire logic spread_enable_in,
  input wire logic rate_range_select_in,
  input wire logic addrStrap0High,
  input wire logic addrStrap0Low,
  input wire logic addrStrap1High,
  input wire logic addrStrap1Low,
  input wire logic cableTypeHigh,
  input wire logic cableTypeLow,
  input wire logic busWidthHigh,
  input wire logic busWidthLow,
  input wire logic pllLocked,
  input wire logic wordAligned,
  input wire logic linkErrEvt,
  input wire logic avStatusWr,
  input wire logic avStatusRd,
  output logic videoLanesOeN,
  output logic [LANES-1:0] videoLaneActive,
  output logic videoClockOeN,
  output logic auxOeN,
  output logic statusIntOut,
  output logic statusIntOeN,
  output logic lockOut,
  output logic lockOeN,
  output logic errOut,
  output logic errOeN,
  output logic twoWireSel,
  output logic bypassMode,
  output logic powerUpState,
  output logic spreadOn,
  output logic rateSlow,
  output logic coaxMode,
  output logic [7:0] devAddr,
  output logic irq
);

  psc_state_t state_r;
  psc_state_t state_nxt;
  psc_straps_t straps;
  psc_lvl_t lvlAddr0, lvlAddr1, lvlCable;
  logic spreadLatch_r, rateLatch_r;
  psc_apb_req_t req;
  logic latchEv;
  logic [31:0] ctrl_r;
  logic [PSC_IRQ_W-1:0] irqStat_r;
  logic [PSC_IRQ_W-1:0] irqMask_r;
  logic lockNow;
  logic lockPrev_r;
  logic avPending;
  logic apbWr;
  logic apbRd;
  logic swAvRead;
  logic [PSC_IRQ_W-1:0] evts;
  logic [7:0] addrBase;
  psc_lvl_t bwLvl;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr,
                 pwdata: pwdata};
  assign apbWr = req.psel && req.penable && req.pwrite && pready;
  assign apbRd = req.psel && req.penable && !req.pwrite && pready;

  ////////////////////////////////////////////////////////////////////////////
  // power state: leaving power-down relatches the straps, which keep their values while down

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PSC_ST_DOWN: begin
        if (power_down_n) state_nxt = PSC_ST_LATCH;
      end
      PSC_ST_LATCH: begin
        state_nxt = power_down_n ? PSC_ST_RUN : PSC_ST_DOWN;
      end
      PSC_ST_RUN: begin
        if (!power_down_n) state_nxt = PSC_ST_DOWN;
      end
      default: state_nxt = PSC_ST_DOWN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= PSC_ST_DOWN;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign latchEv = (state_r == PSC_ST_LATCH);

  ////////////////////////////////////////////////////////////////////////////
  // strap capture

  psc_tri_level u_address_strap_0 (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(latchEv),
    .pinHigh(addrStrap0High),
    .pinLow(addrStrap0Low),
    .level(lvlAddr0)
  );

  psc_tri_level u_address_strap_1 (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(latchEv),
    .pinHigh(addrStrap1High),
    .pinLow(addrStrap1Low),
    .level(lvlAddr1)
  );

  psc_tri_level u_cable (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(latchEv),
    .pinHigh(cableTypeHigh),
    .pinLow(cableTypeLow),
    .level(lvlCable)
  );

  // bus width follows the pin live, decoded through the same cell each cycle
  psc_tri_level u_bws (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(1'b1),
    .pinHigh(busWidthHigh),
    .pinLow(busWidthLow),
    .level(bwLvl)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      spreadLatch_r <= 1'b0;
      rateLatch_r <= 1'b0;
    end else if (latchEv) begin
      spreadLatch_r <= spread_enable_in;
      rateLatch_r <= rate_range_select_in;
    end
  end
  assign straps = {lvlAddr0, lvlAddr1, lvlCable, spreadLatch_r, rateLatch_r};

  always_comb begin
    addrBase = PSC_ADDR_DES_BIT;
    unique case (straps.addr1)
      PSC_LVL_LOW: addrBase = addrBase | 8'h80;
      PSC_LVL_HIGH: addrBase = addrBase | 8'hc0;
      default: addrBase = addrBase | 8'h40;
    endcase
    unique case (straps.addr0)
      PSC_LVL_LOW: addrBase = addrBase;
      PSC_LVL_HIGH: addrBase = addrBase | 8'h04;
      default: addrBase = addrBase | 8'h08;
    endcase
    if (straps.cable == PSC_LVL_OPEN) addrBase = addrBase | PSC_ADDR_OPEN_BIT;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb registers

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= PSC_CTRL_RST;
    end else if (apbWr && req.paddr == PSC_CTRL_OFS) begin
      ctrl_r <= req.pwdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irqMask_r <= '0;
    end else if (apbWr && req.paddr == PSC_MASK_OFS) begin
      irqMask_r <= req.pwdata[PSC_IRQ_W-1:0];
    end
  end

  assign lockNow = pllLocked && wordAligned && power_down_n;
  assign evts[PSC_IRQ_LOCKUP] = lockNow && !lockPrev_r;
  assign evts[PSC_IRQ_LOCKDN] = !lockNow && lockPrev_r;
  assign evts[PSC_IRQ_ERR] = linkErrEvt && power_down_n;
  assign evts[PSC_IRQ_AVNEW] = avStatusWr;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lockPrev_r <= 1'b0;
      irqStat_r <= '0;
    end else begin
      lockPrev_r <= lockNow;
      // set wins over write-one-to-clear
      if (apbWr && req.paddr == PSC_IRQ_OFS) begin
        irqStat_r <= (irqStat_r & ~req.pwdata[PSC_IRQ_W-1:0]) | evts;
      end else begin
        irqStat_r <= irqStat_r | evts;
      end
    end
  end

  assign swAvRead = apbRd && req.paddr == PSC_AVSTAT_OFS;

  psc_edge_flag u_avflag (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .setEvt(avStatusWr || (apbWr && req.paddr == PSC_CTRL_OFS &&
                           req.pwdata[PSC_CTRL_AVNEW])),
    .clrEvt(avStatusRd || swAvRead),
    .flag(avPending)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= req.psel && req.penable && !pready;
      pslverr <= 1'b0;
      if (req.psel && req.penable && !pready) begin
        prdata <= '0;
        unique case (req.paddr)
          PSC_CTRL_OFS: prdata <= ctrl_r;
          PSC_STRAP_OFS: prdata <= {24'h000000, straps};
          PSC_STAT_OFS: prdata <= {24'h000000, twoWireSel, bypassMode, powerUpState,
                                   spreadOn, rateSlow, coaxMode, lockOut, avPending};
          PSC_IRQ_OFS: prdata <= {{(32-PSC_IRQ_W){1'b0}}, irqStat_r};
          PSC_MASK_OFS: prdata <= {{(32-PSC_IRQ_W){1'b0}}, irqMask_r};
          PSC_AVSTAT_OFS: prdata <= {31'h00000000, avPending};
          PSC_ADDR_OFS: prdata <= {24'h000000, devAddr};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin outputs, all registered

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      videoLanesOeN <= 1'b1;
      videoClockOeN <= 1'b1;
      videoLaneActive <= '0;
    end else begin
      videoLanesOeN <= ctrl_r[PSC_CTRL_OUTDIS] || !power_down_n;
      videoClockOeN <= ctrl_r[PSC_CTRL_OUTDIS] || !power_down_n;
      // narrow mode drops the top lane
      videoLaneActive <= (bwLvl == PSC_LVL_LOW) ? {1'b0, {(LANES-1){1'b1}}}
                                                : {LANES{1'b1}};
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      auxOeN <= 1'b1;
      statusIntOeN <= 1'b1;
      statusIntOut <= 1'b0;
    end else begin
      auxOeN <= !aux_output_enable_in;
      statusIntOeN <= !aux_output_enable_in;
      statusIntOut <= avPending;
    end
  end

  // open drain: output held low, enable low pulls the line
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lockOut <= 1'b0;
      lockOeN <= 1'b1;
      errOut <= 1'b0;
      errOeN <= 1'b1;
    end else begin
      lockOut <= 1'b0;
      errOut <= 1'b0;
      lockOeN <= lockNow || !power_down_n;
      errOeN <= !(linkErrEvt && power_down_n);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      twoWireSel <= 1'b0;
      bypassMode <= 1'b0;
      powerUpState <= 1'b0;
      spreadOn <= 1'b0;
      rateSlow <= 1'b0;
      coaxMode <= 1'b0;
      devAddr <= PSC_ADDR_DES_BIT;
      irq <= 1'b0;
    end else begin
      twoWireSel <= protocol_select_in;
      bypassMode <= control_direction_select && link_mode_select_in;
      powerUpState <= !control_direction_select && link_mode_select_in;
      spreadOn <= straps.spread;
      rateSlow <= straps.rateSlow;
      coaxMode <= (straps.cable != PSC_LVL_LOW);
      devAddr <= addrBase;
      irq <= |(irqStat_r & irqMask_r);
    end
  end

endmodule

// *** verification/psc_pin_strap_ctrl_asserts.sv ***
`timescale 1ns/1ps
module psc_pin_strap_ctrl_asserts
  import psc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic power_down_n,
  input wire logic aux_output_enable_in,
  input wire logic protocol_select_in,
  input wire logic link_mode_select_in,
  input wire logic control_direction_select,
  input wire logic pllLocked,
  input wire logic wordAligned,
  input wire logic linkErrEvt,
  input wire logic avStatusWr,
  input wire logic avStatusRd,
  input wire logic auxOeN,
  input wire logic statusIntOut,
  input wire logic statusIntOeN,
  input wire logic lockOeN,
  input wire logic errOeN,
  input wire logic twoWireSel,
  input wire logic bypassMode,
  input wire logic spreadOn,
  input wire logic [7:0] devAddr
);
  logic rstSeen_r;
  // the edge that releases reset still shows reset values, keep it out of every check
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rstSeen_r <= 1'b0;
    end else begin
      rstSeen_r <= 1'b1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSeen_r);
  a_aux_drive: assert property (aux_output_enable_in |=> !auxOeN && !statusIntOeN)
    else $error("aux outputs floating while enabled");
  a_aux_float: assert property (!aux_output_enable_in |=> auxOeN && statusIntOeN)
    else $error("aux outputs driven while disabled");
  a_int_set: assert property (avStatusWr |-> ##2 statusIntOut)
    else $error("interrupt not raised");
  a_int_clear: assert property (avStatusRd && !avStatusWr |-> ##2 !statusIntOut)
    else $error("interrupt not cleared by read");
  a_proto_sel: assert property (1'h1 |=> twoWireSel == $past(protocol_select_in))
    else $error("protocol select not followed");
  a_mode_sel: assert property (control_direction_select |=>
    bypassMode == $past(link_mode_select_in))
    else $error("link mode not followed");
  a_lock_low: assert property (power_down_n && !(pllLocked && wordAligned) |=> !lockOeN)
    else $error("lock released without lock");
  a_lock_high: assert property ((pllLocked && wordAligned) || !power_down_n |=> lockOeN)
    else $error("lock pulled low");
  a_err_pull: assert property (power_down_n && linkErrEvt |=> !errOeN)
    else $error("error not signalled");
  a_err_idle: assert property (!power_down_n || !linkErrEvt |=> errOeN)
    else $error("error pulled low without cause");
  a_strap_hold: assert property (power_down_n [*5] |=> $stable({devAddr, spreadOn}))
    else $error("straps changed while awake");
  a_addr_bit: assert property (power_down_n [*5] |-> devAddr[4])
    else $error("address bit 4 clear");
  c_int: cover property (avStatusWr ##2 statusIntOut);
  c_err: cover property (linkErrEvt && power_down_n);
  c_wake: cover property ($rose(power_down_n));
endmodule

bind psc_pin_strap_ctrl psc_pin_strap_ctrl_asserts u_psc_pin_strap_ctrl_asserts (.*);

// *** verification/psc_strap_board.sv ***
`timescale 1ns/1ps
module psc_strap_board
  import psc_pkg::*;
(
  input wire psc_lvl_t addr0Set,
  input wire psc_lvl_t addr1Set,
  input wire psc_lvl_t cableSet,
  input wire psc_lvl_t bwSet,
  output logic addrStrap0High,
  output logic addrStrap0Low,
  output logic addrStrap1High,
  output logic addrStrap1Low,
  output logic cableTypeHigh,
  output logic cableTypeLow,
  output logic busWidthHigh,
  output logic busWidthLow
);
  // an open strap pulls neither comparator
  assign addrStrap0High = addr0Set == PSC_LVL_HIGH;
  assign addrStrap0Low = addr0Set == PSC_LVL_LOW;
  assign addrStrap1High = addr1Set == PSC_LVL_HIGH;
  assign addrStrap1Low = addr1Set == PSC_LVL_LOW;
  assign cableTypeHigh = cableSet == PSC_LVL_HIGH;
  assign cableTypeLow = cableSet == PSC_LVL_LOW;
  assign busWidthHigh = bwSet == PSC_LVL_HIGH;
  assign busWidthLow = bwSet == PSC_LVL_LOW;
endmodule

// *** verification/pin_strap_status_control_bench.sv ***
`timescale 1ns/1ps
module pin_strap_status_control_bench;
  import psc_pkg::*;
  typedef struct packed {
    psc_lvl_t a1, a0, cab, bw;
    logic sp, rt;
    logic [7:0] adr;
    logic [3:0] ln;
  } psc_row_t;
  logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, power_down_n = 1;
  logic aux_output_enable_in = 0, protocol_select_in = 0, link_mode_select_in = 0;
  logic control_direction_select = 0, spread_enable_in = 0, rate_range_select_in = 0;
  logic pllLocked = 0, wordAligned = 0, linkErrEvt = 0, avStatusWr = 0, avStatusRd = 0;
  logic [7:0] paddr = 8'h00, devAddr;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, videoLanesOeN, videoClockOeN, auxOeN, statusIntOut, statusIntOeN;
  logic lockOut, lockOeN, errOut, errOeN, twoWireSel, bypassMode, powerUpState;
  logic spreadOn, rateSlow, coaxMode, irq;
  logic addrStrap0High, addrStrap0Low, addrStrap1High, addrStrap1Low;
  logic cableTypeHigh, cableTypeLow, busWidthHigh, busWidthLow;
  logic [3:0] videoLaneActive;
  psc_lvl_t addr0Set = PSC_LVL_LOW, addr1Set = PSC_LVL_LOW;
  psc_lvl_t cableSet = PSC_LVL_LOW, bwSet = PSC_LVL_HIGH;
  int nErrors = 0, testsRun = 0;
  psc_row_t rows [6] = '{
    '{PSC_LVL_LOW, PSC_LVL_LOW, PSC_LVL_HIGH, PSC_LVL_LOW, 1'h1, 1'h0, 8'h90, 4'h7},
    '{PSC_LVL_LOW, PSC_LVL_HIGH, PSC_LVL_LOW, PSC_LVL_HIGH, 1'h0, 1'h1, 8'h94, 4'hf},
    '{PSC_LVL_LOW, PSC_LVL_OPEN, PSC_LVL_OPEN, PSC_LVL_OPEN, 1'h1, 1'h1, 8'h9a, 4'hf},
    '{PSC_LVL_HIGH, PSC_LVL_HIGH, PSC_LVL_HIGH, PSC_LVL_HIGH, 1'h0, 1'h0, 8'hd4, 4'hf},
    '{PSC_LVL_OPEN, PSC_LVL_OPEN, PSC_LVL_LOW, PSC_LVL_LOW, 1'h1, 1'h0, 8'h58, 4'h7},
    '{PSC_LVL_HIGH, PSC_LVL_OPEN, PSC_LVL_OPEN, PSC_LVL_HIGH, 1'h1, 1'h1, 8'hda, 4'hf}};

  psc_pin_strap_ctrl u_psc_pin_strap_ctrl (.pclk_en_unused(1'h0), .*);
  psc_strap_board u_psc_strap_board (.*);

  initial forever #2.5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      nErrors++;
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) nErrors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // sleep and wake so the straps are taken again
  task wake();
    @(posedge sys_clk) power_down_n <= 1'h0;
    wt(3);
    @(posedge sys_clk) power_down_n <= 1'h1;
    wt(6);
  endtask

  // bit 0 pulses the status write, bit 1 the status read
  task pulse(input logic [1:0] s);
    @(posedge sys_clk);
    avStatusWr <= s[0];
    avStatusRd <= s[1];
    @(posedge sys_clk);
    avStatusWr <= 1'h0;
    avStatusRd <= 1'h0;
    wt(2);
  endtask

  task results();
    $display("checks %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    nErrors++;
    results();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'h1;
    foreach (rows[i]) begin
      @(posedge sys_clk);
      addr1Set <= rows[i].a1;
      addr0Set <= rows[i].a0;
      cableSet <= rows[i].cab;
      bwSet <= rows[i].bw;
      spread_enable_in <= rows[i].sp;
      rate_range_select_in <= rows[i].rt;
      wake();
      chk("devAddr", rows[i].adr, devAddr);
      chk("lanes", rows[i].ln, videoLaneActive);
      chk("coax", rows[i].cab != PSC_LVL_LOW, coaxMode);
      chk("spread", rows[i].sp, spreadOn);
      chk("rate", rows[i].rt, rateSlow);
    end
    $display("test rows done");
    // pins move while awake: latched copies must not follow
    @(posedge sys_clk);
    addr0Set <= PSC_LVL_LOW;
    spread_enable_in <= 1'h0;
    rate_range_select_in <= 1'h0;
    wt(6);
    chk("held addr", 8'hda, devAddr);
    chk("held spread", 1'h1, spreadOn);
    apb(1'h0, PSC_STRAP_OFS, 32'h0);
    chk("strap codes", 32'h0000009b, rd);
    chk("strap err", 1'h0, er);
    apb(1'h0, PSC_ADDR_OFS, 32'h0);
    chk("addr reg", 32'h000000da, rd);
    apb(1'h0, PSC_STAT_OFS, 32'h0);
    chk("status reg", 32'h0000001c, rd);
    apb(1'h1, PSC_CTRL_OFS, 32'h1);
    wt(2);
    chk("lanes off", 2'h3, {videoLanesOeN, videoClockOeN});
    apb(1'h1, PSC_CTRL_OFS, 32'h0);
    wt(2);
    chk("lanes on", 2'h0, {videoLanesOeN, videoClockOeN});
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped", 1'h1, er);
    $display("test registers done");
    for (int v = 1; v >= 0; v--) begin
      @(posedge sys_clk) aux_output_enable_in <= v[0];
      wt(2);
      chk("aux oe", {2{~v[0]}}, {auxOeN, statusIntOeN});
    end
    apb(1'h1, PSC_IRQ_OFS, 32'hf);
    apb(1'h1, PSC_MASK_OFS, 32'h0);
    pulse(2'h1);
    chk("int set", 1'h1, statusIntOut);
    chk("irq masked", 1'h0, irq);
    apb(1'h1, PSC_MASK_OFS, 32'h8);
    wt(2);
    chk("irq on", 1'h1, irq);
    apb(1'h0, PSC_AVSTAT_OFS, 32'h0);
    chk("av word", 32'h00000001, rd);
    wt(2);
    chk("int read clr", 1'h0, statusIntOut);
    apb(1'h1, PSC_IRQ_OFS, 32'h8);
    wt(2);
    chk("irq clr", 1'h0, irq);
    pulse(2'h1);
    pulse(2'h2);
    chk("int rd clr", 1'h0, statusIntOut);
    // status write and read in one cycle: the new content wins
    pulse(2'h3);
    chk("int set wins", 1'h1, statusIntOut);
    pulse(2'h2);
    apb(1'h1, PSC_CTRL_OFS, 32'h2);
    wt(2);
    chk("int inject", 1'h1, statusIntOut);
    $display("test interrupt done");
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      {protocol_select_in, control_direction_select, link_mode_select_in} <= i[2:0];
      wt(2);
      chk("two wire", i[2], twoWireSel);
      if (i[1]) chk("bypass", i[0], bypassMode);
      else chk("power state", i[0], powerUpState);
    end
    @(posedge sys_clk);
    pllLocked <= 1'h1;
    wt(2);
    chk("lock unaligned", 1'h0, lockOeN);
    @(posedge sys_clk);
    wordAligned <= 1'h1;
    linkErrEvt <= 1'h1;
    wt(2);
    chk("lock", 1'h1, lockOeN);
    chk("err", 1'h0, errOeN);
    chk("od levels", 2'h0, {lockOut, errOut});
    @(posedge sys_clk);
    power_down_n <= 1'h0;
    pllLocked <= 1'h0;
    wt(2);
    chk("pd lock err", 2'h3, {lockOeN, errOeN});
    $display("test link done");
    // mid-run reset: defaults while held, straps taken afresh after release
    @(posedge sys_clk);
    nrst <= 1'h0;
    power_down_n <= 1'h1;
    wt(2);
    chk("rst addr", PSC_ADDR_DES_BIT, devAddr);
    chk("rst oe", 6'h3f, {videoLanesOeN, videoClockOeN, auxOeN, statusIntOeN, lockOeN, errOeN});
    chk("rst int", 1'h0, statusIntOut);
    @(posedge sys_clk);
    nrst <= 1'h1;
    wt(6);
    chk("boot addr", 8'hd2, devAddr);
    chk("boot spread", 1'h0, spreadOn);
    chk("boot rate", 1'h0, rateSlow);
    $display("test reset done");
    results();
  end
endmodule
